// File: hw/bpfs_pkg.sv
// Constants, types and register map for the bus port pin function select.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Behaviour
// - Port E bit 6 set routes pin E3 to sync A, else GPIO.
// - Port E bit 4 set routes pin E2 to sync B, else GPIO.
// - Size functions on E3 and E2 follow only the size-pins enable.
// - E1 field bits 3:2: 0x GPIO, 10 sync A, 11 transfer start.
// - E0 field bits 1:0: 0x GPIO, 10 sync B, 11 transfer in progress.
// - Port E fields reset to all ones in master mode, zeros otherwise.
// - F bit 7 set gives address 23 or chip select 6, else GPIO.
// - F bit 6 set gives address 22 or chip select 5, else GPIO.
// - F bit 5 set gives address 21 or chip select 4, else GPIO.
// - Port F bits 4:0 read zero; writes to them are ignored.
// - Port F assign bits reset to one in master mode, else zero.
// - Port J bits 7:4 route pins to byte strobes 3:0, else GPIO.
// - Port J bits 3:0 route pins to chip selects 3:0, else GPIO.
// - Port J bits reset to one in master mode, else zero; stay R/W.

package bpfs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 24;
  localparam int unsigned DAT_W = 32;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] PORT_E_IDX = 24'h10_0052;
  localparam logic [ADR_W-1:0] PORT_F_IDX = 24'h10_0051;
  localparam logic [ADR_W-1:0] PORT_J_IDX = 24'h10_0054;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned E3_POS = 6;
  localparam int unsigned E2_POS = 4;
  localparam int unsigned E1_LSB = 2;
  localparam int unsigned E0_LSB = 0;
  localparam int unsigned F_LSB  = 5;
  localparam int unsigned F_CNT  = 3;
  localparam int unsigned J_CNT  = 8;
  localparam int unsigned J_BS_LSB = 4;

  // ----------------------------------------------------------------
  // Write masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PE_WMASK      = 16'h005f;
  localparam logic [15:0] PE_RST_MASTER = 16'h005f;
  localparam logic [15:0] PE_RST_SINGLE = 16'h0000;
  localparam logic [7:0]  PF_WMASK      = 8'he0;
  localparam logic [7:0]  PF_RST_MASTER = 8'he0;
  localparam logic [7:0]  PF_RST_SINGLE = 8'h00;
  localparam logic [7:0]  PJ_WMASK      = 8'hff;
  localparam logic [7:0]  PJ_RST_MASTER = 8'hff;
  localparam logic [7:0]  PJ_RST_SINGLE = 8'h00;

  // ----------------------------------------------------------------
  // Two-bit field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PAIR_ALT  = 2'h2;
  localparam logic [1:0] PAIR_PRIM = 2'h3;

  // ----------------------------------------------------------------
  // Pin map: E0..E3, F5..F7, J0..J7
  // ----------------------------------------------------------------
  localparam int unsigned PIN_E_BASE = 0;
  localparam int unsigned PIN_F_BASE = 4;
  localparam int unsigned PIN_J_BASE = 7;
  localparam int unsigned PIN_COUNT  = 15;
  localparam int unsigned E_CNT      = 4;

  typedef enum logic [1:0] {
    ROLE_GPIO,
    ROLE_ALT,
    ROLE_PRIM
  } bpfs_role_t;

endpackage

// File: hw/bpfs_pin_sel.sv
// One pin's output selector: bus function or port GPIO logic.
// Assumes role, sources and GPIO controls come from the same clock domain.

module bpfs_pin_sel
  import bpfs_pkg::*;
(
  input  wire bpfs_role_t role_i,
  input  wire logic       prim_i,
  input  wire logic       alt_i,
  input  wire logic       gpio_out_i,
  input  wire logic       gpio_dir_i,
  output logic            pin_o,
  output logic            oe_n_o
);

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  always_comb begin
    case (role_i)
      ROLE_PRIM: begin
        pin_o  = prim_i;
        oe_n_o = 1'b0;
      end
      ROLE_ALT: begin
        pin_o  = alt_i;
        oe_n_o = 1'b0;
      end
      ROLE_GPIO: begin
        pin_o  = gpio_out_i;
        oe_n_o = ~gpio_dir_i;
      end
      default: begin
        pin_o  = gpio_out_i;
        oe_n_o = 1'b1;
      end
    endcase
  end

endmodule

// File: hw/bpfs_top.sv
// Function select registers and pin multiplexer for ports E, F and J.
// Assumes a classic Wishbone master, a mode strap valid during reset,
// and bus-function signals from logic on clk_i.

module bpfs_top
  import bpfs_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  // Chip configuration
  input  wire logic             master_mode_i,
  input  wire logic             size_pins_enable_i,
  input  wire logic             chip_select_mode_i,
  // Bus functions
  input  wire logic             sync_a_signal_i,
  input  wire logic             sync_b_signal_i,
  input  wire logic             transfer_start_i,
  input  wire logic             transfer_in_progress_i,
  input  wire logic             transfer_size_hi_i,
  input  wire logic             transfer_size_lo_i,
  input  wire logic [2:0]       address_hi_i,
  input  wire logic [6:0]       chip_select_i,
  input  wire logic [3:0]       byte_strobe_i,
  // Port GPIO logic
  input  wire logic [3:0]       gpio_e_out_i,
  input  wire logic [3:0]       gpio_e_dir_i,
  output logic      [3:0]       gpio_e_in_o,
  input  wire logic [2:0]       gpio_f_out_i,
  input  wire logic [2:0]       gpio_f_dir_i,
  output logic      [2:0]       gpio_f_in_o,
  input  wire logic [7:0]       gpio_j_out_i,
  input  wire logic [7:0]       gpio_j_dir_i,
  output logic      [7:0]       gpio_j_in_o,
  // Pins
  input  wire logic [3:0]       pin_e_i,
  output logic      [3:0]       pin_e_o,
  output logic      [3:0]       pin_e_oe_n_o,
  input  wire logic [2:0]       pin_f_i,
  output logic      [2:0]       pin_f_o,
  output logic      [2:0]       pin_f_oe_n_o,
  input  wire logic [7:0]       pin_j_i,
  output logic      [7:0]       pin_j_o,
  output logic      [7:0]       pin_j_oe_n_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] idx);
    return adr[ADR_W-1:2] == idx[ADR_W-3:0];
  endfunction

  function automatic bpfs_role_t bit_role(input logic       b,
                                          input bpfs_role_t on);
    return b ? on : ROLE_GPIO;
  endfunction

  function automatic bpfs_role_t pair_role(input logic [1:0] f);
    bpfs_role_t r;
    r = ROLE_GPIO;
    if (f == PAIR_PRIM) begin
      r = ROLE_PRIM;
    end else if (f == PAIR_ALT) begin
      r = ROLE_ALT;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers and signals
  // ----------------------------------------------------------------
  logic [15:0]          port_e_function_select;
  logic [7:0]           port_f_function_select;
  logic [7:0]           port_j_function_select;
  logic                 bus_req;
  logic                 bus_wr;
  logic                 hit_e;
  logic                 hit_f;
  logic                 hit_j;
  logic [DAT_W-1:0]     rd_word;
  bpfs_role_t           role [PIN_COUNT];
  logic [PIN_COUNT-1:0] prim;
  logic [PIN_COUNT-1:0] alt;
  logic [PIN_COUNT-1:0] gpio_out;
  logic [PIN_COUNT-1:0] gpio_dir;
  logic [PIN_COUNT-1:0] next_pin;
  logic [PIN_COUNT-1:0] next_oe_n;
  logic [PIN_COUNT-1:0] pin_q;
  logic [PIN_COUNT-1:0] oe_n_q;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;

  // ----------------------------------------------------------------
  // Wishbone decode and handshake
  // ----------------------------------------------------------------
  assign bus_req = cyc_i & stb_i;
  assign bus_wr  = bus_req & we_i & ack_o;
  assign hit_e   = reg_hit(adr_i, PORT_E_IDX);
  assign hit_f   = reg_hit(adr_i, PORT_F_IDX);
  assign hit_j   = reg_hit(adr_i, PORT_J_IDX);

  always_comb begin
    rd_word = '0;
    if (hit_e) begin
      rd_word[15:0] = port_e_function_select;
    end else if (hit_f) begin
      rd_word[7:0] = port_f_function_select;
    end else if (hit_j) begin
      rd_word[7:0] = port_j_function_select;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req & ~ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (bus_req & ~ack_o) begin
      dat_o <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Function select registers
  // ----------------------------------------------------------------
  // E reset by mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_e_function_select <= master_mode_i ? PE_RST_MASTER
                                              : PE_RST_SINGLE;
    end else if (bus_wr & hit_e & sel_i[0]) begin
      port_e_function_select <= dat_i[15:0] & PE_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_function_select <= master_mode_i ? PF_RST_MASTER
                                              : PF_RST_SINGLE;
    end else if (bus_wr & hit_f & sel_i[0]) begin
      port_f_function_select <= dat_i[7:0] & PF_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_j_function_select <= master_mode_i ? PJ_RST_MASTER
                                              : PJ_RST_SINGLE;
    end else if (bus_wr & hit_j & sel_i[0]) begin
      port_j_function_select <= dat_i[7:0] & PJ_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Role selection
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < PIN_COUNT; k++) begin
      role[k] = ROLE_GPIO;
    end
    prim = '0;
    alt  = '0;
    role[PIN_E_BASE]   = pair_role(port_e_function_select[E0_LSB +: 2]);
    prim[PIN_E_BASE]   = transfer_in_progress_i;
    alt[PIN_E_BASE]    = sync_b_signal_i;
    role[PIN_E_BASE+1] = pair_role(port_e_function_select[E1_LSB +: 2]);
    prim[PIN_E_BASE+1] = transfer_start_i;
    alt[PIN_E_BASE+1]  = sync_a_signal_i;
    role[PIN_E_BASE+2] = bit_role(port_e_function_select[E2_POS],
                                  ROLE_ALT);
    alt[PIN_E_BASE+2]  = sync_b_signal_i;
    prim[PIN_E_BASE+2] = transfer_size_lo_i;
    role[PIN_E_BASE+3] = bit_role(port_e_function_select[E3_POS],
                                  ROLE_ALT);
    alt[PIN_E_BASE+3]  = sync_a_signal_i;
    prim[PIN_E_BASE+3] = transfer_size_hi_i;
    if (size_pins_enable_i) begin
      role[PIN_E_BASE+2] = ROLE_PRIM;
      role[PIN_E_BASE+3] = ROLE_PRIM;
    end
    for (int k = 0; k < F_CNT; k++) begin
      role[PIN_F_BASE+k] = bit_role(port_f_function_select[F_LSB+k],
                             chip_select_mode_i ? ROLE_ALT : ROLE_PRIM);
      prim[PIN_F_BASE+k] = address_hi_i[k];
      alt[PIN_F_BASE+k]  = chip_select_i[F_LSB-1+k];
    end
    for (int k = 0; k < J_CNT; k++) begin
      role[PIN_J_BASE+k] = bit_role(port_j_function_select[k], ROLE_PRIM);
      if (k < J_BS_LSB) begin
        prim[PIN_J_BASE+k] = chip_select_i[k];
      end else begin
        prim[PIN_J_BASE+k] = byte_strobe_i[k-J_BS_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin selectors
  // ----------------------------------------------------------------
  assign gpio_out = {gpio_j_out_i, gpio_f_out_i, gpio_e_out_i};
  assign gpio_dir = {gpio_j_dir_i, gpio_f_dir_i, gpio_e_dir_i};

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    bpfs_pin_sel u_sel (
      .role_i     (role[g]),
      .prim_i     (prim[g]),
      .alt_i      (alt[g]),
      .gpio_out_i (gpio_out[g]),
      .gpio_dir_i (gpio_dir[g]),
      .pin_o      (next_pin[g]),
      .oe_n_o     (next_oe_n[g])
    );
  end

  // Registered pad drive; released during reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q  <= '0;
      oe_n_q <= '1;
    end else begin
      pin_q  <= next_pin;
      oe_n_q <= next_oe_n;
    end
  end

  assign pin_e_o      = pin_q[PIN_E_BASE +: E_CNT];
  assign pin_e_oe_n_o = oe_n_q[PIN_E_BASE +: E_CNT];
  assign pin_f_o      = pin_q[PIN_F_BASE +: F_CNT];
  assign pin_f_oe_n_o = oe_n_q[PIN_F_BASE +: F_CNT];
  assign pin_j_o      = pin_q[PIN_J_BASE +: J_CNT];
  assign pin_j_oe_n_o = oe_n_q[PIN_J_BASE +: J_CNT];

  // ----------------------------------------------------------------
  // Pin input synchronisers toward GPIO logic
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {pin_j_i, pin_f_i, pin_e_i};
      pin_sync <= pin_meta;
    end
  end

  assign gpio_e_in_o = pin_sync[PIN_E_BASE +: E_CNT];
  assign gpio_f_in_o = pin_sync[PIN_F_BASE +: F_CNT];
  assign gpio_j_in_o = pin_sync[PIN_J_BASE +: J_CNT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Routing checks skip the last reset edge: pads still show reset drive
  e3_sync_route_a: assert property (
    (!rst_i && !size_pins_enable_i && port_e_function_select[E3_POS])
    |=> (pin_e_o[3] == $past(sync_a_signal_i)) && !pin_e_oe_n_o[3]
  ) else $error("pin E3 does not carry sync A");

  e2_sync_route_a: assert property (
    (!rst_i && !size_pins_enable_i && port_e_function_select[E2_POS])
    |=> (pin_e_o[2] == $past(sync_b_signal_i)) && !pin_e_oe_n_o[2]
  ) else $error("pin E2 does not carry sync B");

  size_override_a: assert property (
    !rst_i && size_pins_enable_i
    |=> (pin_e_o[3] == $past(transfer_size_hi_i))
        && (pin_e_o[2] == $past(transfer_size_lo_i))
        && (pin_e_oe_n_o[3:2] == 2'h0)
  ) else $error("size pins not driven while enabled");

  e1_start_route_a: assert property (
    !rst_i && (port_e_function_select[E1_LSB +: 2] == PAIR_PRIM)
    |=> pin_e_o[1] == $past(transfer_start_i)
  ) else $error("pin E1 does not carry transfer start");

  e0_field_route_a: assert property (
    !rst_i && (port_e_function_select[E0_LSB +: 2] == PAIR_ALT)
    |=> pin_e_o[0] == $past(sync_b_signal_i)
  ) else $error("pin E0 does not carry sync B");

  e_reset_mode_a: assert property (
    $fell(rst_i) |-> port_e_function_select ==
      ($past(master_mode_i) ? PE_RST_MASTER : PE_RST_SINGLE)
  ) else $error("port E reset value wrong for mode");

  f7_select_route_a: assert property (
    (!rst_i && port_f_function_select[F_LSB+2] && chip_select_mode_i)
    |=> pin_f_o[2] == $past(chip_select_i[6])
  ) else $error("pin F7 does not carry chip select 6");

  f5_address_route_a: assert property (
    (!rst_i && port_f_function_select[F_LSB] && !chip_select_mode_i)
    |=> pin_f_o[0] == $past(address_hi_i[0])
  ) else $error("pin F5 does not carry address bit 21");

  f_reserved_read_a: assert property (
    (ack_o && !we_i && hit_f) |-> dat_o[4:0] == 5'h00
  ) else $error("port F reserved bits read nonzero");

  j_reset_mode_a: assert property (
    $fell(rst_i) |-> port_j_function_select ==
      ($past(master_mode_i) ? PJ_RST_MASTER : PJ_RST_SINGLE)
  ) else $error("port J reset value wrong for mode");

  j_write_take_a: assert property (
    (bus_wr && hit_j && sel_i[0])
    |=> port_j_function_select == $past(dat_i[7:0])
  ) else $error("port J write not stored");

  j_strobe_route_a: assert property (
    !rst_i && port_j_function_select[7]
    |=> pin_j_o[7] == $past(byte_strobe_i[3])
  ) else $error("pin J7 does not carry byte strobe 3");

  j_gpio_route_a: assert property (
    !rst_i && !port_j_function_select[0]
    |=> (pin_j_o[0] == $past(gpio_j_out_i[0]))
        && (pin_j_oe_n_o[0] == !$past(gpio_j_dir_i[0]))
  ) else $error("pin J0 not under GPIO control");

endmodule

// File: sim/bpfs_far_side.sv
// Far-side model: external bus controller and port GPIO logic.
// Assumes the bench sets polarity and direction between pin checks.
module bpfs_far_side (
  input  wire logic clk_i,
  input  wire logic pol_i,
  input  wire logic dir_i,
  output logic      prim_o,
  output logic      alt_o,
  output logic      alt_b_o,
  output logic      gout_o,
  output logic      gdir_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Source levels
  // ----------------------------------------------------------------
  // Primary and alternate sources opposite, so the chosen role shows
  // Sync B and GPIO value differ from sync A over the three pin steps
  always_ff @(posedge clk_i) begin
    prim_o  <= pol_i;
    alt_o   <= ~pol_i;
    alt_b_o <= pol_i ^ dir_i;
  end

  always_ff @(posedge clk_i) begin
    gout_o <= ~(pol_i ^ dir_i);
    gdir_o <= dir_i;
  end
endmodule

// File: sim/test_bpfs_top.sv
// Self-checking bench for the port E/F/J function select block.
// Assumes the far-side model drives all bus-function and GPIO inputs.
module test_bpfs_top
  import bpfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] AD_E = 24'h40_0148;
  localparam logic [ADR_W-1:0] AD_F = 24'h40_0144;
  localparam logic [ADR_W-1:0] AD_J = 24'h40_0150;
  localparam logic [ADR_W-1:0] AD_X = 24'h40_014c;

  typedef struct packed {
    logic [7:0] pe;
    logic [7:0] pf;
    logic [7:0] pj;
    logic       sz;
    logic       cs;
    logic [7:0] er;
    logic [5:0] fr;
  } bpfs_row_t;

  // Expected roles per pin: 0 GPIO, 1 sync A or select, 2 primary, 3 sync B
  bpfs_row_t rows [6] = '{
    '{8'h5f, 8'he0, 8'ha5, 1'h0, 1'h0, 8'h7a, 6'h2a},
    '{8'h0a, 8'he0, 8'h5a, 1'h0, 1'h1, 8'h07, 6'h15},
    '{8'h45, 8'ha0, 8'hff, 1'h0, 1'h0, 8'h40, 6'h22},
    '{8'h13, 8'h40, 8'h00, 1'h1, 1'h1, 8'ha2, 6'h04},
    '{8'h00, 8'h1f, 8'h0f, 1'h1, 1'h0, 8'ha0, 6'h00},
    '{8'hff, 8'hff, 8'hff, 1'h0, 1'h1, 8'h7a, 6'h15}
  };

  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             cyc = 1'h0;
  logic             stb = 1'h0;
  logic             we  = 1'h0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0]       sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic [DAT_W-1:0] got;
  logic             ack;
  logic             mm = 1'h1, sz = 1'h0, csm = 1'h0, pol = 1'h0, dir = 1'h0;
  logic             prim, alt, alt_b, gout, gdir;
  logic [3:0]       pe_i = '0, pe_o, pe_oe, ge_in;
  logic [2:0]       pf_i = '0, pf_o, pf_oe, gf_in;
  logic [7:0]       pj_i = '0, pj_o, pj_oe, gj_in;
  int               n_fail = 0, cmp_count = 0, cyc_n = 0;

  always #5 clk = ~clk;

  bpfs_far_side far_u (.clk_i(clk), .pol_i(pol), .dir_i(dir),
    .prim_o(prim), .alt_o(alt), .alt_b_o(alt_b), .gout_o(gout),
    .gdir_o(gdir));

  bpfs_top dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .master_mode_i(mm), .size_pins_enable_i(sz),
    .chip_select_mode_i(csm), .sync_a_signal_i(alt), .sync_b_signal_i(alt_b),
    .transfer_start_i(prim), .transfer_in_progress_i(prim),
    .transfer_size_hi_i(prim), .transfer_size_lo_i(prim),
    .address_hi_i({3{prim}}), .chip_select_i({{3{alt}}, {4{prim}}}),
    .byte_strobe_i({4{prim}}), .gpio_e_out_i({4{gout}}),
    .gpio_e_dir_i({4{gdir}}), .gpio_e_in_o(ge_in), .gpio_f_out_i({3{gout}}),
    .gpio_f_dir_i({3{gdir}}), .gpio_f_in_o(gf_in), .gpio_j_out_i({8{gout}}),
    .gpio_j_dir_i({8{gdir}}), .gpio_j_in_o(gj_in), .pin_e_i(pe_i),
    .pin_e_o(pe_o), .pin_e_oe_n_o(pe_oe), .pin_f_i(pf_i), .pin_f_o(pf_o),
    .pin_f_oe_n_o(pf_oe), .pin_j_i(pj_i), .pin_j_o(pj_o),
    .pin_j_oe_n_o(pj_oe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [DAT_W-1:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'h1);
    got = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic rdc(input string nm, input logic [ADR_W-1:0] a,
                     input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000, 4'h1);
    chk(nm, e, got);
  endtask

  // Pin level and active-low enable for a role under current sources
  function automatic logic [1:0] pv(input logic [1:0] r);
    if (r == 2'h3) return {pol ^ dir, 1'h0};
    if (r == 2'h2) return {pol, 1'h0};
    if (r == 2'h1) return {~pol, 1'h0};
    return {~(pol ^ dir), ~dir};
  endfunction

  task automatic pins(input logic [7:0] er, input logic [5:0] fr,
                      input logic [7:0] jm);
    logic [3:0] eo, ee;
    logic [2:0] fo, fe;
    logic [7:0] jo, je;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) {eo[k], ee[k]} = pv(er[2*k+:2]);
    for (int k = 0; k < 3; k++) {fo[k], fe[k]} = pv(fr[2*k+:2]);
    for (int k = 0; k < 8; k++) {jo[k], je[k]} = pv({jm[k], 1'h0});
    chk("pin_e", {ee, eo}, {pe_oe, pe_o});
    chk("pin_f", {fe, fo}, {pf_oe, pf_o});
    chk("pin_j", {je, jo}, {pj_oe, pj_o});
  endtask

  task automatic do_reset(input logic m);
    rst <= 1'h1;
    mm <= m;
    repeat (3) @(posedge clk);
    chk("rst_out", 32'h0000_7fff, {ack, pe_oe, pf_oe, pj_oe});
    rst <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'h1);
    rdc("e_master", AD_E, 32'h0000_005f);
    rdc("f_master", AD_F, 32'h0000_00e0);
    rdc("j_master", AD_J, 32'h0000_00ff);
    pins(8'h7a, 6'h2a, 8'hff);
    do_reset(1'h0);
    rdc("e_single", AD_E, 32'h0000_0000);
    rdc("f_single", AD_F, 32'h0000_0000);
    rdc("j_single", AD_J, 32'h0000_0000);
    pins(8'h00, 6'h00, 8'h00);
    wb(1'h1, AD_J, 32'h0000_00ff, 4'h0);
    rdc("j_nosel", AD_J, 32'h0000_0000);
    wb(1'h1, AD_X, 32'h0000_00ff, 4'h1);
    rdc("unmapped", AD_X, 32'h0000_0000);
    foreach (rows[i]) begin
      sz <= rows[i].sz;
      csm <= rows[i].cs;
      wb(1'h1, AD_E, {24'h00_0000, rows[i].pe}, 4'h1);
      wb(1'h1, AD_F, {24'h00_0000, rows[i].pf}, 4'h1);
      wb(1'h1, AD_J, {24'h00_0000, rows[i].pj}, 4'h1);
      rdc("e_back", AD_E, rows[i].pe & 8'h5f);
      rdc("f_back", AD_F, rows[i].pf & 8'he0);
      rdc("j_back", AD_J, rows[i].pj);
      for (int k = 0; k < 3; k++) begin
        pol <= (k != 0);
        dir <= (k == 2);
        pins(rows[i].er, rows[i].fr, rows[i].pj);
      end
    end
    pe_i <= 4'ha;
    pf_i <= 3'h5;
    pj_i <= 8'h3c;
    repeat (4) @(posedge clk);
    chk("gpio_in", 32'h0000_53ca, {gf_in, gj_in, ge_in});
    do_reset(1'h1);
    rdc("j_rerst", AD_J, 32'h0000_00ff);
    stop_test();
  end
endmodule
